/* design/gpx_port.sv */
// What this block does
// - Eight pins, each independently an input or an output.
// - Bit x of latch, direction and option registers belongs to pin x.
// - Direction zero makes an input; latch read returns the live pin level.
// - Latch writes in input mode store the value, the pin stays input.
// - Option bit picks floating or pull-up for an input.
// - Direction/option: 00 floating, 01 pull-up, 10 open-drain, 11 push-pull.
// - Option set on an input with interrupt capability raises its vector on edges.
// - Software picks falling or rising edge per vector in edge sense control.
// - Up to seven vectors; several pins may share one.
// - Pins sharing a vector are ANDed, so one low pin masks others.
// - Vector fetch clears the pending latch; no software flag exists.
// - Changing a vector's sense bit discards its pending request.
// - Direction one drives the latch; latch read returns the stored value.
// - Push-pull drives 0 and 1; open-drain drives 0, floats for 1.
// - Peripheral output enable overrides direction and data, driving the pin.
// - Input pin with alternate output: latch read returns the alternate value.
// - Output pin with alternate input: peripheral sees the latch content.
// - Floating input routes the pin to the peripheral input.
// - Request is passed on only when configured and global mask clear.
// - Idle modes leave port state; any pending request wakes the device.
`timescale 1ns/1ps
`default_nettype none
module gpx_port #(
    parameter int          NPIN    = gpx_pkg::NPIN,
    parameter int          NVEC    = gpx_pkg::NVEC,
    parameter logic [23:0] PIN_VEC = gpx_pkg::PIN_VEC_DFLT,
    parameter logic [7:0]  IRQ_CAP = gpx_pkg::RST_CAP
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic [gpx_pkg::ADDR_W-1:0] paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [7:0]                pin_in,
    output logic      [7:0]                pin_out,
    output logic      [7:0]                pin_oe_n,
    output logic      [7:0]                pin_pullup,
    input  wire logic [7:0]                alt_out_en,
    input  wire logic [7:0]                alt_out_val,
    output logic      [7:0]                alt_in_val,
    input  wire logic                      cc_int_mask,
    input  wire logic [6:0]                vec_fetch,
    output logic      [6:0]                irq_req,
    output logic                           wake_req
);
    // Registers
    logic [7:0] pin_data_latch_r;
    logic [7:0] pin_direction_bit_r;
    logic [7:0] pin_option_bit_r;
    logic [6:0] edge_sense_control_r;
    logic [6:0] pend_r;
    logic [6:0] pend_nxt;
    logic [6:0] lvl_prev_r;
    logic [31:0] prdata_nxt;

    // Pin levels after two flip-flops
    logic [7:0] pin_sync;

    gpx_sync2 #(
        .WIDTH   (8),
        .RST_VAL (8'hff)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // Bus decode
    wire        bus_setup  = psel && !penable;
    wire        bus_done   = psel && penable && pready;
    wire        bus_wr     = bus_done && pwrite && pstrb[0];
    wire        hit_data   = (paddr == gpx_pkg::OFS_DATA);
    wire        hit_dir    = (paddr == gpx_pkg::OFS_DIR);
    wire        hit_opt    = (paddr == gpx_pkg::OFS_OPT);
    wire        hit_sense  = (paddr == gpx_pkg::OFS_SENSE);
    wire        hit_any    = hit_data | hit_dir | hit_opt | hit_sense;
    wire        wr_data    = bus_wr && hit_data;
    wire        wr_dir     = bus_wr && hit_dir;
    wire        wr_opt     = bus_wr && hit_opt;
    wire        wr_sense   = bus_wr && hit_sense;
    wire [6:0]  sense_chg  = wr_sense ? (pwdata[6:0] ^ edge_sense_control_r) : 7'h00;

    // Per pin view
    wire [7:0]  is_out     = pin_direction_bit_r;
    wire [7:0]  drv_low    = is_out & ~pin_option_bit_r;
    // Per bit choice: a peripheral drives only the pins it has enabled
    wire [7:0]  pad_read   = (alt_out_en & alt_out_val) | (~alt_out_en & pin_sync);
    wire [7:0]  latch_view = (is_out & ~alt_out_en & pin_data_latch_r)
                           | (~(is_out & ~alt_out_en) & pad_read);
    wire [7:0]  pad_val    = (alt_out_en & alt_out_val)
                           | (~alt_out_en & pin_data_latch_r);
    wire [7:0]  pad_drive  = alt_out_en
                           | (is_out & (pin_option_bit_r | ~pin_data_latch_r));
    wire [7:0]  pull_on    = ~is_out & pin_option_bit_r & ~alt_out_en;
    wire [7:0]  alt_in_nxt = (is_out & pin_data_latch_r) | (~is_out & pin_sync);
    wire [7:0]  pin_irq_en = ~is_out & pin_option_bit_r & IRQ_CAP & ~alt_out_en;

    // Vector level combine and edge detection
    wire [6:0]  vec_lvl;
    wire [6:0]  vec_edge;

    genvar v, p;
    generate
        for (v = 0; v < NVEC; v++) begin : g_vec
            wire [7:0] memb;
            for (p = 0; p < NPIN; p++) begin : g_memb
                assign memb[p] = pin_irq_en[p]
                               && (PIN_VEC[p*gpx_pkg::VEC_W +: gpx_pkg::VEC_W] == 3'(v));
            end
            assign vec_lvl[v]  = &(pin_sync | ~memb);
            assign vec_edge[v] = (edge_sense_control_r[v] == gpx_pkg::SENSE_RISE)
                               ? (vec_lvl[v] && !lvl_prev_r[v])
                               : (!vec_lvl[v] && lvl_prev_r[v]);
            // Sense change wins; a new edge wins over a fetch
            assign pend_nxt[v] = sense_chg[v] ? 1'b0
                               : (vec_edge[v] || (pend_r[v] && !vec_fetch[v]));
        end
    endgenerate

    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit_data) begin
            prdata_nxt[7:0] = latch_view;
        end else if (hit_dir) begin
            prdata_nxt[7:0] = pin_direction_bit_r;
        end else if (hit_opt) begin
            prdata_nxt[7:0] = pin_option_bit_r;
        end else if (hit_sense) begin
            prdata_nxt[6:0] = edge_sense_control_r;
        end
    end

    // Bus answer, no wait states
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= bus_setup;
            pslverr <= bus_setup && !hit_any;
            if (bus_setup && !pwrite) begin
                prdata <= prdata_nxt;
            end
        end
    end

    // Software registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_data_latch_r     <= gpx_pkg::RST_DATA;
            pin_direction_bit_r  <= gpx_pkg::RST_DIR;
            pin_option_bit_r     <= gpx_pkg::RST_OPT;
            edge_sense_control_r <= gpx_pkg::RST_SENSE;
        end else begin
            if (wr_data) begin
                pin_data_latch_r <= pwdata[7:0];
            end
            if (wr_dir) begin
                pin_direction_bit_r <= pwdata[7:0];
            end
            if (wr_opt) begin
                pin_option_bit_r <= pwdata[7:0];
            end
            if (wr_sense) begin
                edge_sense_control_r <= pwdata[6:0];
            end
        end
    end

    // Request latches and previous levels
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pend_r     <= 7'h00;
            lvl_prev_r <= 7'h7f;
        end else begin
            pend_r     <= pend_nxt;
            lvl_prev_r <= vec_lvl;
        end
    end

    // Registered pad and CPU side outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_out    <= 8'hff;
            pin_oe_n   <= 8'hff;
            pin_pullup <= 8'h00;
            alt_in_val <= 8'hff;
            irq_req    <= 7'h00;
            wake_req   <= 1'b0;
        end else begin
            pin_out    <= pad_val;
            pin_oe_n   <= ~pad_drive;
            pin_pullup <= pull_on;
            alt_in_val <= alt_in_nxt;
            irq_req    <= cc_int_mask ? 7'h00 : pend_r;
            wake_req   <= |pend_r;
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    sequence s_dir_write;
        s_setup ##1 (s_access and (pwrite && hit_dir && pstrb[0]));
    endsequence

    chk_reset_dir_clear: assert property (
        $past(rst_n) == 1'b0 |-> (pin_direction_bit_r == 8'h00 && pend_r == 7'h00))
        else $error("direction or pending not cleared by reset");

    chk_dir_write_lands: assert property (
        s_dir_write |=> pin_direction_bit_r == $past(pwdata[7:0]))
        else $error("direction write not stored");

    chk_input_read_live: assert property (
        (bus_setup && !pwrite && hit_data) |=>
            (((prdata[7:0] ^ $past(pin_sync))
              & $past(~pin_direction_bit_r & ~alt_out_en)) == 8'h00))
        else $error("input read not from pin level");

    chk_output_drives: assert property (
        1'b1 |=> (((pin_out ^ $past(pin_data_latch_r))
                   & $past(pin_direction_bit_r & ~alt_out_en)) == 8'h00))
        else $error("output pin not driving latch");

    chk_open_drain_float: assert property (
        1'b1 |=> ((~pin_oe_n & $past(drv_low & pin_data_latch_r & ~alt_out_en)) == 8'h00))
        else $error("open drain drives a one");

    chk_alt_override: assert property (
        1'b1 |=> (((pin_out ^ $past(alt_out_val)) | pin_oe_n) & $past(alt_out_en)) == 8'h00)
        else $error("alternate output not in control");

    chk_alt_in_latch: assert property (
        1'b1 |=> (((alt_in_val ^ $past(pin_data_latch_r))
                   & $past(pin_direction_bit_r)) == 8'h00))
        else $error("alternate input not fed from latch");

    chk_sense_clear: assert property (
        (sense_chg != 7'h00) |=> ((pend_r & $past(sense_chg)) == 7'h00))
        else $error("sense change left a request pending");

    chk_edge_pends: assert property (
        (vec_edge != 7'h00 && sense_chg == 7'h00)
            |=> ((pend_r & $past(vec_edge)) == $past(vec_edge)))
        else $error("edge did not raise request");

    chk_fetch_clear: assert property (
        (vec_fetch != 7'h00 && vec_edge == 7'h00)
            |=> ((pend_r & $past(vec_fetch)) == 7'h00))
        else $error("fetch did not clear request");

    chk_irq_masked: assert property (
        cc_int_mask |=> irq_req == 7'h00 ##1 1'b1)
        else $error("request passed while masked");

    chk_wake_follows: assert property (
        (pend_r != 7'h00) |=> wake_req)
        else $error("pending request did not wake");

    chk_pull_input: assert property (
        1'b1 |=> ((pin_pullup ^ $past(~pin_direction_bit_r & pin_option_bit_r & ~alt_out_en)) == 8'h00))
        else $error("pull-up does not follow input option");

    chk_input_undriven: assert property (
        1'b1 |=> ((~pin_oe_n & $past(~pin_direction_bit_r & ~alt_out_en)) == 8'h00))
        else $error("input pin is driven");

    chk_push_pull_drives: assert property (
        1'b1 |=> ((pin_oe_n & $past(pin_direction_bit_r & pin_option_bit_r)) == 8'h00))
        else $error("push-pull pin released");

    chk_alt_in_float: assert property (
        1'b1 |=> (((alt_in_val ^ $past(pin_sync)) & $past(~pin_direction_bit_r)) == 8'h00))
        else $error("alternate input not fed from pin");

    chk_alt_read_back: assert property (
        (bus_setup && !pwrite && hit_data) |=>
            (((prdata[7:0] ^ $past(alt_out_val)) & $past(~pin_direction_bit_r & alt_out_en)) == 8'h00))
        else $error("input read ignores alternate output");

    chk_output_read_latch: assert property (
        (bus_setup && !pwrite && hit_data) |=>
            (((prdata[7:0] ^ $past(pin_data_latch_r)) & $past(pin_direction_bit_r & ~alt_out_en)) == 8'h00))
        else $error("output read not from latch");

    chk_sense_write: assert property (
        wr_sense |=> edge_sense_control_r == $past(pwdata[6:0]))
        else $error("edge sense write not stored");

    chk_latch_write: assert property (
        wr_data |=> pin_data_latch_r == $past(pwdata[7:0]))
        else $error("latch write not stored");

    chk_unmasked_passes: assert property (
        !cc_int_mask |=> irq_req == $past(pend_r))
        else $error("unmasked request not passed");

    chk_pend_needs_edge: assert property (
        1'b1 |=> ((pend_r & ~$past(pend_r) & ~$past(vec_edge)) == 7'h00))
        else $error("request raised without an edge");

    chk_reset_pins: assert property (
        $past(rst_n) == 1'b0 |-> (pin_oe_n == 8'hff && irq_req == 7'h00 && !wake_req))
        else $error("pins or requests not idle after reset");

    chk_wake_clears: assert property (
        (pend_r == 7'h00) |=> !wake_req)
        else $error("wake without pending request");

    chk_sense_holds: assert property (
        !wr_sense |=> $stable(edge_sense_control_r))
        else $error("edge sense changed without write");

    chk_dir_holds: assert property (
        !wr_dir |=> $stable(pin_direction_bit_r))
        else $error("direction changed without write");

    chk_latch_holds: assert property (
        !wr_data |=> $stable(pin_data_latch_r))
        else $error("latch changed without write");

    sequence s_new_edge;
        (vec_edge != 7'h00) && (sense_chg == 7'h00);
    endsequence

    chk_edge_to_irq: assert property (
        s_new_edge ##1 !cc_int_mask
            |=> ((irq_req & $past(vec_edge, 2)) == $past(vec_edge, 2)))
        else $error("edge did not reach request output");

endmodule // gpx_port
`default_nettype wire

/* include/gpx_pkg.sv */
`default_nettype none
package gpx_pkg;
    // Port shape
    localparam int          NPIN      = 8;
    localparam int          NVEC      = 7;
    localparam int          VEC_W     = 3;
    localparam logic [2:0]  VEC_NONE  = 3'h7;

    // Default pin to vector map, three bits per pin, pin 0 lowest
    localparam logic [23:0] PIN_VEC_DFLT = 24'hfac688;

    // APB register map, byte addresses
    localparam int          ADDR_W    = 8;
    localparam logic [7:0]  OFS_DATA  = 8'h00;
    localparam logic [7:0]  OFS_DIR   = 8'h04;
    localparam logic [7:0]  OFS_OPT   = 8'h08;
    localparam logic [7:0]  OFS_SENSE = 8'h0c;

    // Reset values
    localparam logic [7:0]  RST_DATA  = 8'hff;
    localparam logic [7:0]  RST_DIR   = 8'h00;
    localparam logic [7:0]  RST_OPT   = 8'h00;
    localparam logic [6:0]  RST_SENSE = 7'h00;
    localparam logic [7:0]  RST_CAP   = 8'hff;

    // Edge sense field encoding, one bit per vector
    localparam logic        SENSE_FALL = 1'b0;
    localparam logic        SENSE_RISE = 1'b1;
endpackage
`default_nettype wire

/* design/gpx_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module gpx_sync2 #(
    parameter int          WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [WIDTH-1:0]  async_in,
    output logic      [WIDTH-1:0]  sync_out
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_r   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // gpx_sync2
`default_nettype wire

/* sim/gpx_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gpx_pad_model (
    input  wire logic       mclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] flt_r = 8'h55;

    // Undriven pad with no pull-up wanders every cycle
    always @(posedge mclk) begin
        flt_r <= ~flt_r;
    end

    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en & (pin_pullup | flt_r));
endmodule // gpx_pad_model
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk = 0;
    logic        rst_n = 0;
    logic [7:0]  paddr = '0;
    logic        psel = 0, penable = 0, pwrite = 0, cc_int_mask = 0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, wake_req, err;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup, alt_in_val;
    logic [7:0]  alt_out_en = '0, alt_out_val = '0, ext_val = 8'hff, ext_en = 8'hff;
    logic [6:0]  vec_fetch = '0, irq_req;
    int          bad_count = 0, comparisons = 0;

    always #25 mclk = ~mclk;

    // Pins 6 and 7 share vector 6
    gpx_port #(.PIN_VEC(24'hdac688)) u_gpx_port (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
        .alt_out_en(alt_out_en), .alt_out_val(alt_out_val), .alt_in_val(alt_in_val),
        .cc_int_mask(cc_int_mask), .vec_fetch(vec_fetch), .irq_req(irq_req),
        .wake_req(wake_req));

    gpx_pad_model u_gpx_pad_model (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n = 0;
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n == 20) begin
            bad_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Expected pad level and drive enable from the programmed mode
    function automatic logic [15:0] pins_x(input logic [7:0] dir, dat, opt, aen, aval, ext);
        logic [7:0] oe;
        logic [7:0] o;
        oe = ~(aen | (dir & (opt | ~dat)));
        o = (aen & aval) | (~aen & dat);
        return {oe, (~oe & o) | (oe & ext)};
    endfunction

    initial begin
        logic [7:0]  dat, dir, opt, aen, aval, oe, lv;
        logic [7:0]  ofs [4];
        logic        s;
        int          v;
        int          n;
        ofs = '{gpx_pkg::OFS_DATA, gpx_pkg::OFS_DIR, gpx_pkg::OFS_OPT, gpx_pkg::OFS_SENSE};
        void'($urandom(31));
        repeat (4) @(posedge mclk);
        rst_n <= 1;
        chk("pin_oe_n reset", 32'(pin_oe_n), 32'hff);
        for (int i = 0; i < 4; i++) begin
            apb(0, ofs[i], 0, 4'hf);
            chk("reset read", rd, (i == 0) ? 32'hff : 32'h0);
        end
        apb(0, 8'h10, 0, 4'hf);
        chk("unmapped err", 32'(err), 1);
        chk("unmapped data", rd, 0);
        apb(1, gpx_pkg::OFS_DIR, 32'hff, 4'hf);
        apb(1, gpx_pkg::OFS_DATA, 32'h55, 4'hf);
        apb(1, gpx_pkg::OFS_DATA, 32'haa, 4'he);
        apb(0, gpx_pkg::OFS_DATA, 0, 4'hf);
        chk("strobe ignored", rd, 32'h55);
        $display("register map test done");
        for (int i = 0; i < 24; i++) begin
            dat = 8'($urandom);
            dir = 8'($urandom);
            opt = 8'($urandom);
            aval = 8'($urandom);
            aen = 8'($urandom) & ~dir;
            if (i < 2) begin
                dir = 8'hff;
                opt = {8{i[0]}};
                aen = 0;
            end
            // Released pads only where the pull-up holds them
            ext_en <= 8'($urandom) | ~(~dir & opt & ~aen);
            ext_val <= 8'($urandom);
            alt_out_en <= aen;
            alt_out_val <= aval;
            apb(1, gpx_pkg::OFS_DATA, 32'(dat), 4'hf);
            apb(1, gpx_pkg::OFS_DIR, 32'(dir), 4'hf);
            apb(1, gpx_pkg::OFS_OPT, 32'(opt), 4'hf);
            // Pull-up turns on a cycle late, then two sync stages and the output flop
            repeat (6) @(posedge mclk);
            {oe, lv} = pins_x(dir, dat, opt, aen, aval, ext_val | ~ext_en);
            chk("pin_oe_n", 32'(pin_oe_n), 32'(oe));
            chk("pin_out", 32'(pin_out & ~oe), 32'(lv & ~oe));
            chk("pin_pullup", 32'(pin_pullup & ~aen), 32'(~dir & opt & ~aen));
            chk("alt_in_val", 32'(alt_in_val), 32'((dir & dat) | (~dir & lv)));
            apb(0, gpx_pkg::OFS_DATA, 0, 4'hf);
            chk("data read", rd, 32'((dir & dat) | (~dir & lv)));
            apb(0, gpx_pkg::OFS_DIR, 0, 4'hf);
            chk("dir read", rd, 32'(dir));
        end
        // Drop all interrupt members, then flush requests left by the random modes
        alt_out_en <= 0;
        ext_en <= 8'hff;
        ext_val <= 8'hff;
        apb(1, gpx_pkg::OFS_OPT, 0, 4'hf);
        repeat (4) @(posedge mclk);
        vec_fetch <= 7'h7f;
        @(posedge mclk);
        vec_fetch <= 0;
        $display("pin mode test done");
        for (v = 0; v < 7; v++) begin
            s = 1'($urandom);
            ext_val <= s ? ~(8'h1 << v) : 8'hff;
            apb(1, gpx_pkg::OFS_DIR, 0, 4'hf);
            apb(1, gpx_pkg::OFS_SENSE, 32'(s) << v, 4'hf);
            apb(1, gpx_pkg::OFS_OPT, 32'h1 << v, 4'hf);
            repeat (6) @(posedge mclk);
            chk("irq idle", 32'(irq_req[v]), 0);
            ext_val[v] <= s;
            for (n = 0; n < 10 && irq_req[v] !== 1'b1; n++) @(posedge mclk);
            chk("irq raised", 32'(irq_req[v]), 1);
            if (irq_req[v] !== 1'b1) results();
            chk("wake", 32'(wake_req), 1);
            vec_fetch[v] <= 1;
            @(posedge mclk);
            vec_fetch <= 0;
            repeat (3) @(posedge mclk);
            chk("irq fetched", 32'(irq_req[v]), 0);
        end
        cc_int_mask <= 1;
        ext_val[6] <= ~s;
        repeat (3) @(posedge mclk);
        ext_val[6] <= s;
        repeat (6) @(posedge mclk);
        chk("irq masked", 32'(irq_req[6]), 0);
        chk("wake masked", 32'(wake_req), 1);
        cc_int_mask <= 0;
        repeat (3) @(posedge mclk);
        chk("irq unmasked", 32'(irq_req[6]), 1);
        apb(1, gpx_pkg::OFS_SENSE, ~(32'(s) << 6), 4'hf);
        repeat (3) @(posedge mclk);
        chk("sense discard", 32'(wake_req), 0);
        $display("interrupt test done");
        // Two members on vector 6, falling sense
        apb(1, gpx_pkg::OFS_SENSE, 0, 4'hf);
        ext_val <= 8'h3f;
        apb(1, gpx_pkg::OFS_OPT, 32'hc0, 4'hf);
        repeat (4) @(posedge mclk);
        vec_fetch <= 7'h40;
        @(posedge mclk);
        vec_fetch <= 0;
        ext_val[6] <= 1'b1;
        repeat (4) @(posedge mclk);
        ext_val[6] <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("shared masked", 32'(irq_req[6]), 0);
        ext_val[7] <= 1'b1;
        repeat (4) @(posedge mclk);
        ext_val[6] <= 1'b1;
        repeat (4) @(posedge mclk);
        ext_val[7] <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("shared edge", 32'(irq_req[6]), 1);
        $display("shared vector test done");
        // Reset in mid-run with a request pending and outputs enabled
        apb(1, gpx_pkg::OFS_DIR, 32'h0f, 4'hf);
        rst_n <= 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1;
        chk("reset wake", 32'(wake_req), 0);
        chk("reset irq", 32'(irq_req), 0);
        chk("reset pins", 32'(pin_oe_n), 32'hff);
        apb(0, gpx_pkg::OFS_DIR, 0, 4'hf);
        chk("reset dir", rd, 0);
        $display("reset test done");
        results();
    end
endmodule // testbench
`default_nettype wire
